/* File: pafo_defines.vh */
// Purpose: shared constants for the pin override port block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses
`ifndef PAFO_DEFINES_VH
`define PAFO_DEFINES_VH

`define PAFO_ADDR_W 4
`define PAFO_OFF_DRIVE 4'h0
`define PAFO_OFF_LEVEL 4'h4
`define PAFO_OFF_SAMPLE 4'h8
`define PAFO_OFF_CTRL 4'hC

`define PAFO_CTRL_PULLOFF_BIT 0
`define PAFO_CTRL_SLEEP_BIT 1

`define PAFO_RST_DRIVE 1'h0
`define PAFO_RST_LEVEL 1'h0
`define PAFO_RST_PULLOFF 1'h0
`define PAFO_RST_SAMPLE 1'h0

`define PAFO_DATA_W 32
`define PAFO_ZERO_WORD 32'h0000_0000

`endif

/* File: pafo_port.v */
// Purpose: general-purpose port with per-pin alternate function override
// Assumes: pad and peripheral inputs synchronous to pclk except pad_in
// Notes: overrides other than toggle act combinationally; registers read back stored values, except the control sleep bit, which reads sleep_ctrl live
// Notes on behaviour
// - override enable selects pull-up from override value, else normal pull-up logic.
// - with pull-up override, value one turns pull-up on, zero off.
// - direction override enable selects output enable from override path, else drive bit.
// - with direction override, value one enables driver, zero disables it.
// - level override plus enabled output drives override value, else stored level bit.
// - toggle override inverts the stored level bit of that pin.
// - input gate override selects gate from override value, else run/sleep state.
// - with input gate override, gate follows override value regardless of sleep.
// - schmitt tap goes out before the synchroniser; peripheral syncs it itself.
// - analog pad net passes straight through with no digital gating.
// - normal pull-up on only for input, level one, global pull-up not off.
// - pin sampled by a low-phase latch then rising-edge register.
// - writing one to sample register bit inverts the level bit; zero ignored.
// - sleep without override clamps the digital input low.
`timescale 1ns/10ps
`default_nettype none
`include "pafo_defines.vh"

module pafo_port #(
  parameter PINS = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PAFO_ADDR_W-1:0] paddr,
  input wire [`PAFO_DATA_W-1:0] pwdata,
  output wire pready,
  output wire pslverr,
  output wire [`PAFO_DATA_W-1:0] prdata,
  // power manager
  input wire sleep_ctrl,
  // peripheral override controls
  input wire [PINS-1:0] pullup_override_en,
  input wire [PINS-1:0] pullup_override_val,
  input wire [PINS-1:0] drive_select_override_en,
  input wire [PINS-1:0] drive_select_override_val,
  input wire [PINS-1:0] out_level_override_en,
  input wire [PINS-1:0] out_level_override_val,
  input wire [PINS-1:0] toggle_override_en,
  input wire [PINS-1:0] input_gate_override_en,
  input wire [PINS-1:0] input_gate_override_val,
  // peripheral input tap
  output wire [PINS-1:0] schmitt_input_tap,
  // pad side
  input wire [PINS-1:0] pad_in,
  output wire [PINS-1:0] pad_out,
  output wire [PINS-1:0] pad_oe,
  output wire [PINS-1:0] pad_pullup_en,
  output wire [PINS-1:0] pad_input_en,
  // analog path
  input wire [PINS-1:0] analog_pad_in,
  output wire [PINS-1:0] analog_pad_net
);

  // width of the read bits above the pins
  localparam PAD_W = `PAFO_DATA_W - PINS;

  // per-pin state lives in g_pin; these vectors gather it for read-back
  wire [PINS-1:0] port_drive_bits;
  wire [PINS-1:0] port_level_bits;
  wire [PINS-1:0] port_sampled_bits;
  reg global_pullup_off_reg;

  // bus side
  reg [`PAFO_DATA_W-1:0] prdata_reg;
  reg [`PAFO_DATA_W-1:0] rd_word;
  reg slverr_reg;
  reg addr_ok;
  wire setup_ph;
  wire wr_acc;
  wire wr_drive;
  wire wr_level;
  wire wr_sample;
  wire wr_ctrl;
  wire [PINS-1:0] wr_bits;
  wire [`PAFO_DATA_W-1:0] drive_word;
  wire [`PAFO_DATA_W-1:0] level_word;
  wire [`PAFO_DATA_W-1:0] sample_word;

  // pin side
  wire [PINS-1:0] dig_in_en;
  wire [PINS-1:0] gated_in;

  // apb: data is captured in the setup cycle so the access phase has no wait
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & ~slverr_reg;
  assign pready = 1'h1;
  assign pslverr = psel & penable & slverr_reg;
  assign prdata = prdata_reg;

  // one strobe per register, all behind the refused-address gate in wr_acc
  assign wr_drive = wr_acc & (paddr == `PAFO_OFF_DRIVE);
  assign wr_level = wr_acc & (paddr == `PAFO_OFF_LEVEL);
  assign wr_sample = wr_acc & (paddr == `PAFO_OFF_SAMPLE);
  assign wr_ctrl = wr_acc & (paddr == `PAFO_OFF_CTRL);
  assign wr_bits = pwdata[PINS-1:0];

  // read words; bits above the pin count read as zero
  assign drive_word = {{PAD_W{1'h0}}, port_drive_bits};
  assign level_word = {{PAD_W{1'h0}}, port_level_bits};
  assign sample_word = {{PAD_W{1'h0}}, port_sampled_bits};

  // address check kept apart from the read mux; it also gates writes
  always @* begin
    case (paddr)
      `PAFO_OFF_DRIVE, `PAFO_OFF_LEVEL, `PAFO_OFF_SAMPLE, `PAFO_OFF_CTRL: begin
        addr_ok = 1'h1;
      end
      default: begin
        addr_ok = 1'h0;
      end
    endcase
  end

  always @* begin
    rd_word = `PAFO_ZERO_WORD;
    case (paddr)
      `PAFO_OFF_DRIVE: begin
        rd_word = drive_word;
      end
      `PAFO_OFF_LEVEL: begin
        rd_word = level_word;
      end
      `PAFO_OFF_SAMPLE: begin
        rd_word = sample_word;
      end
      `PAFO_OFF_CTRL: begin
        rd_word[`PAFO_CTRL_PULLOFF_BIT] = global_pullup_off_reg;
        rd_word[`PAFO_CTRL_SLEEP_BIT] = sleep_ctrl;
      end
      default: begin
        rd_word = `PAFO_ZERO_WORD;
      end
    endcase
  end

  // read data is loaded at the setup edge and holds until the next setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `PAFO_ZERO_WORD;
    end else if (setup_ph) begin
      prdata_reg <= pwrite ? `PAFO_ZERO_WORD : rd_word;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slverr_reg <= 1'h0;
    end else if (setup_ph) begin
      slverr_reg <= ~addr_ok;
    end
  end

  // control register: only the global pull-up switch is writable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_pullup_off_reg <= `PAFO_RST_PULLOFF;
    end else if (wr_ctrl) begin
      global_pullup_off_reg <= pwdata[`PAFO_CTRL_PULLOFF_BIT];
    end
  end

  // clamped low when the gate is closed so a floating pad causes no leakage
  assign gated_in = pad_in & dig_in_en;
  assign pad_input_en = dig_in_en;
  assign schmitt_input_tap = gated_in;

  // no digital logic on the analog net
  assign analog_pad_net = analog_pad_in;

  // everything below repeats per pin with no cross-pin terms, so an override
  // on one pin never reaches another
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_pin
      // stored state
      reg drive_reg;
      reg level_reg;
      reg level_next;
      reg latch_reg;
      reg sampled_reg;

      // combinational selects
      reg pu_norm;
      reg pullup_sel;
      reg oe_sel;
      reg out_sel;
      reg gate_sel;

      // direction bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          drive_reg <= `PAFO_RST_DRIVE;
        end else if (wr_drive) begin
          drive_reg <= wr_bits[i];
        end
      end

      // level bit: direct write, software toggle and peripheral toggle all
      // apply, so a toggle in the same cycle as a write is not lost
      always @* begin
        level_next = level_reg;
        if (wr_level) begin
          level_next = wr_bits[i];
        end
        if (wr_sample) begin
          level_next = level_next ^ wr_bits[i];
        end
        if (toggle_override_en[i]) begin
          level_next = ~level_next;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_reg <= `PAFO_RST_LEVEL;
        end else begin
          level_reg <= level_next;
        end
      end

      // normal pull-up: input, level one, not switched off globally
      always @* begin
        if (!drive_reg && level_reg && !global_pullup_off_reg) begin
          pu_norm = 1'h1;
        end else begin
          pu_norm = 1'h0;
        end
      end

      always @* begin
        if (pullup_override_en[i]) begin
          pullup_sel = pullup_override_val[i];
        end else begin
          pullup_sel = pu_norm;
        end
      end

      // output enable
      always @* begin
        if (drive_select_override_en[i]) begin
          oe_sel = drive_select_override_val[i];
        end else begin
          oe_sel = drive_reg;
        end
      end

      // driven level: the level override only counts while the driver is on
      always @* begin
        if (out_level_override_en[i] && oe_sel) begin
          out_sel = out_level_override_val[i];
        end else begin
          out_sel = level_reg;
        end
      end

      // digital input gate
      always @* begin
        if (input_gate_override_en[i]) begin
          gate_sel = input_gate_override_val[i];
        end else begin
          gate_sel = ~sleep_ctrl;
        end
      end

      // sampler: low-phase latch modelled on the falling edge, then rising
      // edge, giving a half to one and a half cycle lag; latch feeds only the
      // register
      always @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
          latch_reg <= `PAFO_RST_SAMPLE;
        end else begin
          latch_reg <= gated_in[i];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sampled_reg <= `PAFO_RST_SAMPLE;
        end else begin
          sampled_reg <= latch_reg;
        end
      end

      // gather for read-back and pads
      assign port_drive_bits[i] = drive_reg;
      assign port_level_bits[i] = level_reg;
      assign port_sampled_bits[i] = sampled_reg;
      assign pad_pullup_en[i] = pullup_sel;
      assign pad_oe[i] = oe_sel;
      assign pad_out[i] = out_sel;
      assign dig_in_en[i] = gate_sel;
    end
  endgenerate

endmodule // pafo_port

`default_nettype wire

/* File: pafo_sva.sv */
// Purpose: pin override checker
// Assumes: one clock, overrides other than toggle act at once
// Notes: bound to pafo_port
`timescale 1ns/10ps
`default_nettype none
module pafo_sva #(parameter PINS = 8) (
  input wire logic pclk, presetn, psel, sleep_ctrl,
  input wire logic [PINS-1:0] pullup_override_en, pullup_override_val,
  input wire logic [PINS-1:0] drive_select_override_en, drive_select_override_val,
  input wire logic [PINS-1:0] out_level_override_en, out_level_override_val,
  input wire logic [PINS-1:0] toggle_override_en,
  input wire logic [PINS-1:0] input_gate_override_en, input_gate_override_val,
  input wire logic [PINS-1:0] pad_in, pad_out, pad_oe, pad_pullup_en, pad_input_en,
  input wire logic [PINS-1:0] schmitt_input_tap, analog_pad_in, analog_pad_net
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PU: assert property (
    ((pad_pullup_en ^ pullup_override_val) & pullup_override_en) == 0) else $error("pull-up");
  AST_DIR: assert property (
    ((pad_oe ^ drive_select_override_val) & drive_select_override_en) == 0) else $error("dir");
  AST_LVL: assert property (
    ((pad_out ^ out_level_override_val) & out_level_override_en & pad_oe) == 0)
    else $error("level");
  AST_GATE: assert property (
    ((pad_input_en ^ input_gate_override_val) & input_gate_override_en) == 0)
    else $error("gate");
  AST_SLEEP: assert property (
    (pad_input_en & ~input_gate_override_en) == ({PINS{!sleep_ctrl}} & ~input_gate_override_en))
    else $error("sleep");
  AST_TAP: assert property (schmitt_input_tap == (pad_in & pad_input_en))
    else $error("tap");
  AST_ANA: assert property (analog_pad_net == analog_pad_in) else $error("analog");
  // psel low excludes a register write landing on the same edge
  AST_TOG: assert property (
    !psel && toggle_override_en[0] && !out_level_override_en[0] ##1 !out_level_override_en[0]
    |-> pad_out[0] != $past(pad_out[0])) else $error("toggle");
endmodule // pafo_sva
bind pafo_port pafo_sva #(.PINS(PINS)) i_sva (.*);
`default_nettype wire

/* File: pafo_periph.sv */
// Purpose: peripheral taking over the pins
// Assumes: one enable and value pattern for all pins; toggle is set per pin
// Notes: tap is resynchronised here, not in the port
`timescale 1ns/10ps
`default_nettype none
module pafo_periph (
  input wire logic pclk,
  input wire logic [3:0] en, val,
  input wire logic [7:0] tog, schmitt_input_tap,
  output wire logic [7:0] pullup_override_en, pullup_override_val, drive_select_override_en,
  output wire logic [7:0] drive_select_override_val, out_level_override_en,
  output wire logic [7:0] out_level_override_val, toggle_override_en,
  output wire logic [7:0] input_gate_override_en, input_gate_override_val,
  output logic [7:0] tap_sync
);
  logic [7:0] s1;
  assign {pullup_override_en, drive_select_override_en} = {{8{en[3]}}, {8{en[2]}}};
  assign {out_level_override_en, input_gate_override_en} = {{8{en[1]}}, {8{en[0]}}};
  assign {pullup_override_val, drive_select_override_val} = {{8{val[3]}}, {8{val[2]}}};
  assign {out_level_override_val, input_gate_override_val} = {{8{val[1]}}, {8{val[0]}}};
  assign toggle_override_en = tog;
  always @(posedge pclk) begin
    {tap_sync, s1} <= {s1, schmitt_input_tap};
  end
endmodule // pafo_periph
`default_nettype wire

/* File: port_alternate_function_override_tb_top.sv */
// Purpose: testbench of pafo_port
// Assumes: apb with no wait states expected, bounded anyway
// Notes: rows {en, val, drive level pulloff sleep, pu oe out ine}
`timescale 1ns/10ps
`default_nettype none
module port_alternate_function_override_tb_top;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic sleep_ctrl = 1'h0, pready, pslverr, err_seen;
  logic [3:0] paddr = 4'h0, en = 4'h0, val = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] pad_in = 8'h0, analog_pad_in = 8'h96, tog = 8'h0;
  logic [7:0] pad_out, pad_oe, pad_pullup_en, pad_input_en, analog_pad_net, schmitt_input_tap;
  logic [7:0] pullup_override_en, pullup_override_val, drive_select_override_en, tap_sync;
  logic [7:0] drive_select_override_val, out_level_override_en, out_level_override_val;
  logic [7:0] toggle_override_en, input_gate_override_en, input_gate_override_val;
  logic [15:0] rows [8] = '{16'h004B, 16'h0063, 16'h00C7, 16'h0001, 16'h0010, 16'hFD7D,
                            16'hF2C2, 16'h40C3};
  int errors = 0, checks_done = 0;
  pafo_port #(.PINS(8)) i_dut (.*);
  pafo_periph i_periph (.*);
  always #5 pclk = ~pclk;
  task automatic stop_test(input bit hung);
    if (hung) errors++;
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1 && ++n < 9);
    rd = prdata;
    err_seen = pslverr;
    if (n == 9) stop_test(1'h1);
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int a = 0; a < 16; a += 4) begin
      apb(1'h0, a[3:0], 32'h0);
      chk(rd, 32'h0);
    end
    foreach (rows[i]) begin
      {en, val, sleep_ctrl, pad_in} <= {rows[i][15:8], rows[i][4], 8'hA5};
      apb(1'h1, 4'h0, {24'h0, {8{rows[i][7]}}});
      apb(1'h1, 4'h4, {24'h0, {8{rows[i][6]}}});
      apb(1'h1, 4'hC, {31'h0, rows[i][5]});
      chk({pad_pullup_en, pad_oe, pad_out, pad_input_en}, {{8{rows[i][3]}}, {8{rows[i][2]}},
          {8{rows[i][1]}}, {8{rows[i][0]}}});
      chk(schmitt_input_tap, 8'hA5 & {8{rows[i][0]}});
      apb(1'h0, 4'h4, 32'h0);
      chk(rd, {24'h0, {8{rows[i][6]}}});
    end
    chk(analog_pad_net, 8'h96);
    {en, pad_in} <= {4'h0, 8'h3C};
    repeat (2) @(posedge pclk);
    apb(1'h0, 4'h8, 32'h0);
    chk(rd, 32'h3C);
    chk(tap_sync, 8'h3C);
    apb(1'h1, 4'h8, 32'h3);
    apb(1'h1, 4'h8, 32'h0);
    apb(1'h0, 4'h4, 32'h0);
    chk(rd, 32'hFC);
    tog <= 8'h01;
    @(posedge pclk);
    tog <= 8'h00;
    apb(1'h0, 4'h4, 32'h0);
    chk(rd, 32'hFD);
    // offset 2 lies between registers, so it must be refused
    apb(1'h1, 4'h2, 32'hFF);
    chk(err_seen, 1'h1);
    apb(1'h0, 4'h4, 32'h0);
    chk(rd, 32'hFD);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk(pad_pullup_en, 8'h00);
    apb(1'h0, 4'h4, 32'h0);
    chk(rd, 32'h0);
    stop_test(1'h0);
  end
endmodule // port_alternate_function_override_tb_top
`default_nettype wire
